// ==== dcmp_ctrl.sv ====
// Dual-channel DDR2 map and power control top level.
// Assumes the request path and DLL/IO macros are on mclk; link clock is async.
`include "dcmp_consts.svh"
module dcmp_ctrl
	import dcmp_pkg::*;
(
	input wire logic mclk, // Core clock, 250 MHz.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic link_clk, // Memory link clock, asynchronous.
	input wire logic req_valid, // Request strobe.
	input wire logic req_write, // Request is a write.
	input wire logic [`DCMP_ADDR_W-1:0] req_addr, // System address.
	input wire logic [3:0] req_rank, // One-hot target rank of request.
	input wire logic [1:0] map_mode, // From channel_control_reg mode.
	input wire logic [1:0] chan_sel_field, // channel_control_reg select.
	input wire logic xor_en, // Hash enable.
	input wire dcmp_size_t rank_boundary_regs_a, // Channel A top.
	input wire dcmp_size_t rank_boundary_regs_b, // Channel B top.
	input wire logic [3:0] rank_present, // Populated ranks.
	input wire logic [3:0] page_8k, // Per-rank page size, 1 for 8k.
	input wire logic [2:0] spd_freq_a, // Module A max speed code.
	input wire logic [2:0] spd_freq_b, // Module B max speed code.
	input wire logic pending, // Memory cycles outstanding.
	input wire logic rd_active, // Read burst on the bus.
	input wire logic wr_active, // Write burst on the bus.
	input wire logic [3:0] burst_rank, // One-hot rank of current burst.
	input wire logic suspend_req, // Enter suspend_to_ram_state.
	input wire logic dpd_en, // Dynamic power-down enable.
	input wire logic dpd_mode, // 0 active, 1 precharge power-down.
	input wire logic refresh_req, // Refresh due.
	input wire logic refresh_done, // Refresh finished.
	input wire logic pages_closed, // All pages precharged.
	output logic map_valid, // Mapped request strobe.
	output logic map_chan, // Mapped channel.
	output logic [`DCMP_ADDR_W-1:0] map_addr, // Channel address.
	output logic map_page_8k, // Page size for mapped rank.
	output logic [2:0] mem_freq_sel, // Chosen memory speed code.
	output logic precharge_all, // Close pages request.
	output logic refresh_go, // Issue refresh now.
	output logic [3:0] ck_en, // Clock pair enables, 2 per slot.
	output logic [3:0] cke_out, // CKE levels.
	output logic [3:0] cke_oe, // CKE output enables.
	output logic [3:0] cs_en, // Chip select enables.
	output logic addr_ctl_oe, // Address/command buffer enable.
	output logic [3:0] odt_out, // DRAM termination controls.
	output logic own_odt, // Controller-side termination.
	output logic dll_en, // Master and slave DLLs.
	output logic [1:0] receive_enable_timing_dll_en, // receive_enable_timing DLLs.
	output logic data_sa_en, // Data/strobe sense amps.
	output logic out_sa_en, // Output-only sense amps.
	output logic self_refresh, // All ranks in self refresh.
	output logic link_seen // Link clock edge seen recently.
);
	typedef enum logic [2:0] {
		ST_RUN,
		ST_FLUSH,
		ST_SREF,
		ST_CLOSE,
		ST_PDOWN,
		ST_REFRESH
	} dcmp_state_e;

	localparam logic [3:0] PRE_CYC = 4'(`DCMP_PRECHARGE_CYC);

	dcmp_state_e state_reg, state_next;
	logic [3:0] wait_reg;
	logic link_s1_reg, link_s2_reg, link_s3_reg;
	logic [1:0] slot_pop;
	logic [3:0] cke_next;

	// Per-slot population; each slot carries two ranks.
	assign slot_pop = {|rank_present[3:2], |rank_present[1:0]};

	dcmp_addr_map i_dcmp_addr_map (
		.mclk(mclk),
		.srst(srst),
		.req_valid(req_valid),
		.req_addr(req_addr),
		.map_mode(map_mode),
		.sel_bit(chan_sel_field),
		.xor_en(xor_en),
		.bound_a(rank_boundary_regs_a),
		.bound_b(rank_boundary_regs_b),
		.map_valid(map_valid),
		.map_chan(map_chan),
		.map_addr(map_addr)
	);

	// Page size registered alongside the map so they line up.
	always_ff @(posedge mclk) begin
		if (srst) begin
			map_page_8k <= 1'b0;
		end else begin
			map_page_8k <= |(req_rank & page_8k);
		end
	end

	// The slower code wins; an empty slot does not vote, except that with both slots empty slot A's code is used.
	always_ff @(posedge mclk) begin
		if (srst) begin
			mem_freq_sel <= 3'h0;
		end else if (slot_pop == 2'h3) begin
			mem_freq_sel <= (spd_freq_a < spd_freq_b) ?
				spd_freq_a : spd_freq_b;
		end else if (slot_pop[1]) begin
			mem_freq_sel <= spd_freq_b;
		end else begin
			mem_freq_sel <= spd_freq_a;
		end
	end

	// Link clock passes two flops before the edge detector reads it.
	always_ff @(posedge mclk) begin
		if (srst) begin
			link_s1_reg <= 1'b0;
			link_s2_reg <= 1'b0;
			link_s3_reg <= 1'b0;
			link_seen <= 1'b0;
		end else begin
			link_s1_reg <= link_clk;
			link_s2_reg <= link_s1_reg;
			link_s3_reg <= link_s2_reg;
			link_seen <= link_s2_reg & ~link_s3_reg;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
		ST_RUN: begin
			if (suspend_req) begin
				state_next = ST_FLUSH;
			end else if (dpd_en && !pending && !refresh_req) begin
				state_next = dpd_mode ? ST_CLOSE : ST_PDOWN;
			end
		end
		ST_FLUSH: begin
			if (!pending) begin
				state_next = ST_SREF;
			end
		end
		ST_SREF: begin
			if (!suspend_req) begin
				state_next = ST_RUN;
			end
		end
		ST_CLOSE: begin
			if (pages_closed && wait_reg == 4'h0) begin
				state_next = ST_PDOWN;
			end
		end
		ST_PDOWN: begin
			if (suspend_req) begin
				state_next = ST_FLUSH;
			end else if (refresh_req) begin
				state_next = ST_REFRESH;
			end else if (pending || !dpd_en) begin
				state_next = ST_RUN;
			end
		end
		ST_REFRESH: begin
			if (refresh_done) begin
				state_next = dpd_en ? ST_PDOWN : ST_RUN;
			end
		end
		default: state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Holds off power-down until the precharge has had time to settle.
	always_ff @(posedge mclk) begin
		if (srst) begin
			wait_reg <= 4'h0;
		end else if (state_reg != ST_CLOSE) begin
			wait_reg <= PRE_CYC;
		end else if (wait_reg != 4'h0) begin
			wait_reg <= wait_reg - 4'h1;
		end
	end

	always_comb begin
		case (state_next)
		ST_SREF: cke_next = 4'h0;
		ST_PDOWN: cke_next = 4'h0;
		default: cke_next = rank_present;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cke_out <= 4'h0;
			cke_oe <= 4'h0;
			precharge_all <= 1'b0;
			refresh_go <= 1'b0;
			self_refresh <= 1'b0;
		end else begin
			cke_out <= cke_next;
			cke_oe <= rank_present;
			precharge_all <= (state_next == ST_CLOSE);
			// Refresh only goes out once CKE is already high again, and
			// drops on the same edge that puts the ranks back to sleep.
			refresh_go <= (state_reg == ST_REFRESH) &&
				(state_next == ST_REFRESH);
			self_refresh <= (state_next == ST_SREF);
		end
	end

	// Buffer and clock gating, registered so pins change cleanly.
	always_ff @(posedge mclk) begin
		if (srst) begin
			ck_en <= 4'h0;
			cs_en <= 4'h0;
			addr_ctl_oe <= 1'b0;
			dll_en <= 1'b1;
			receive_enable_timing_dll_en <= 2'h0;
			data_sa_en <= 1'b0;
			out_sa_en <= 1'b0;
		end else begin
			ck_en <= {{`DCMP_CLK_PAIRS{slot_pop[1]}},
				{`DCMP_CLK_PAIRS{slot_pop[0]}}};
			cs_en <= cke_next & rank_present;
			addr_ctl_oe <= |cke_next;
			dll_en <= !(state_next == ST_SREF);
			receive_enable_timing_dll_en <= slot_pop;
			data_sa_en <= (state_next != ST_SREF) && (pending
				|| rd_active);
			out_sa_en <= 1'b0;
		end
	end

	// Termination follows the burst direction and its target rank.
	always_ff @(posedge mclk) begin
		if (srst) begin
			odt_out <= 4'h0;
			own_odt <= 1'b0;
		end else if (wr_active) begin
			odt_out <= burst_rank & rank_present;
			own_odt <= 1'b0;
		end else if (rd_active) begin
			odt_out <= 4'h0;
			own_odt <= 1'b1;
		end else begin
			odt_out <= 4'h0;
			own_odt <= 1'b0;
		end
	end
endmodule

// ==== dcmp_consts.svh ====
// Constants for the dual-channel memory map and power control block.
// Assumes inclusion by dcmp_pkg.sv and the design modules; definitions only.
`ifndef DCMP_CONSTS_SVH
`define DCMP_CONSTS_SVH
`define DCMP_ADDR_W 33
`define DCMP_SIZE_W 9
`define DCMP_SIZE_SHIFT 24
`define DCMP_LINE_BIT 6
`define DCMP_RANKS 2
`define DCMP_CLK_PAIRS 2
`define DCMP_PRECHARGE_NS 20
`define DCMP_CLK_NS 4
`define DCMP_PRECHARGE_CYC \
	((`DCMP_PRECHARGE_NS + `DCMP_CLK_NS - 1) / `DCMP_CLK_NS)
`define DCMP_SEL_FIELD_W 2
`endif

// ==== dcmp_pkg.sv ====
// Types shared by the memory map and power control modules.
// Assumes dcmp_consts.svh is on the include path.
`include "dcmp_consts.svh"
package dcmp_pkg;
	typedef enum logic [1:0] {
		DCMP_MAP_ASYM,
		DCMP_MAP_INTLV,
		DCMP_MAP_FLEX
	} dcmp_map_e;
	typedef enum logic {
		DCMP_PD_ACTIVE,
		DCMP_PD_PRECHARGE
	} dcmp_pd_e;
	typedef logic [`DCMP_SIZE_W-1:0] dcmp_size_t;
endpackage

// ==== dcmp_addr_map.sv ====
// Address mapper: picks the channel and channel-local address for a request.
// Assumes sizes are in 16 MB units and stable while requests flow.
`include "dcmp_consts.svh"
module dcmp_addr_map
	import dcmp_pkg::*;
(
	input wire logic mclk, // Clock.
	input wire logic srst, // Synchronous reset.
	input wire logic req_valid, // Request strobe.
	input wire logic [`DCMP_ADDR_W-1:0] req_addr, // System address.
	input wire logic [1:0] map_mode, // Mapping style.
	input wire logic [`DCMP_SEL_FIELD_W-1:0] sel_bit, // Interleave select.
	input wire logic xor_en, // Fold hashing into channel choice.
	input wire dcmp_size_t bound_a, // Channel A top.
	input wire dcmp_size_t bound_b, // Channel B top.
	output logic map_valid, // Mapped request strobe.
	output logic map_chan, // 0 for A, 1 for B.
	output logic [`DCMP_ADDR_W-1:0] map_addr // Channel address.
);
	localparam int AW = `DCMP_ADDR_W;
	localparam int SH = `DCMP_SIZE_SHIFT;
	logic [AW-1:0] top_a, top_b, small_sz, flex_edge;
	logic hash_bit, sel_raw, chan_next;
	logic [AW-1:0] addr_next;
	logic [AW-1:0] squeezed;

	assign top_a = AW'({bound_a, {SH{1'b0}}});
	assign top_b = AW'({bound_b, {SH{1'b0}}});
	assign small_sz = (top_a < top_b) ? top_a : top_b;
	// The flex edge is twice the smaller channel.
	assign flex_edge = AW'({small_sz, 1'b0});
	assign hash_bit = xor_en ? ^req_addr[19:12] : 1'b0;

	always_comb begin
		case (sel_bit)
		2'h0: sel_raw = req_addr[6];
		2'h1: sel_raw = req_addr[7];
		2'h2: sel_raw = req_addr[8];
		default: sel_raw = req_addr[9];
		endcase
	end

	// Drop the select bit so each channel sees a dense address.
	always_comb begin
		squeezed = '0;
		case (sel_bit)
		2'h0: squeezed = {1'b0, req_addr[AW-1:7], req_addr[5:0]};
		2'h1: squeezed = {1'b0, req_addr[AW-1:8], req_addr[6:0]};
		2'h2: squeezed = {1'b0, req_addr[AW-1:9], req_addr[7:0]};
		default: squeezed = {1'b0, req_addr[AW-1:10], req_addr[8:0]};
		endcase
	end

	always_comb begin
		chan_next = 1'b0;
		addr_next = req_addr;
		case (map_mode)
		DCMP_MAP_INTLV: begin
			chan_next = sel_raw ^ hash_bit;
			addr_next = squeezed;
		end
		DCMP_MAP_FLEX: begin
			if (req_addr < flex_edge) begin
				chan_next = req_addr[`DCMP_LINE_BIT] ^ hash_bit;
				addr_next = {1'b0, req_addr[AW-1:7], req_addr[5:0]};
			end else begin
				chan_next = (top_b > top_a);
				addr_next = req_addr - small_sz;
			end
		end
		default: begin
			if (req_addr < top_a) begin
				chan_next = 1'b0;
				addr_next = req_addr;
			end else begin
				chan_next = 1'b1;
				addr_next = req_addr - top_a;
			end
		end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			map_valid <= 1'b0;
			map_chan <= 1'b0;
			map_addr <= '0;
		end else begin
			map_valid <= req_valid;
			map_chan <= chan_next;
			map_addr <= addr_next;
		end
	end
endmodule

// ==== dcmp_ctrl_monitor.sv ====
// Checker for dcmp_ctrl: strobe, termination and power relations.
// Assumes it is bound to dcmp_ctrl and sees only its ports.
module dcmp_ctrl_monitor (
	input wire logic mclk, // Clock.
	input wire logic srst, // Reset.
	input wire logic req_valid, // Request.
	input wire logic map_valid, // Mapped.
	input wire logic [3:0] rank_present, // Ranks.
	input wire logic pending, // Busy.
	input wire logic rd_active, // Read.
	input wire logic wr_active, // Write.
	input wire logic [3:0] burst_rank, // Target.
	input wire logic [3:0] cke_out, // CKE.
	input wire logic [3:0] cs_en, // Selects.
	input wire logic addr_ctl_oe, // Bus on.
	input wire logic [3:0] odt_out, // DRAM ODT.
	input wire logic own_odt, // Own ODT.
	input wire logic dll_en, // DLLs.
	input wire logic data_sa_en, // Data amps.
	input wire logic out_sa_en, // Out amps.
	input wire logic self_refresh, // Sleeping.
	input wire logic refresh_go // Refresh.
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	a_map_strobe: assert property (req_valid |=> map_valid)
		else $error("mapped strobe missing");
	a_cs_gated: assert property ((cs_en & ~cke_out) == 4'h0)
		else $error("select on with clock enable low");
	a_bus_quiet: assert property (cke_out == 4'h0 |-> !addr_ctl_oe)
		else $error("address bus on with all CKE low");
	a_write_odt: assert property (wr_active && !rd_active |=>
		!own_odt && odt_out == ($past(burst_rank) & $past(rank_present)))
		else $error("write termination wrong");
	a_read_odt: assert property (rd_active && !wr_active |=>
		own_odt && odt_out == 4'h0)
		else $error("read termination wrong");
	a_sref_dll: assert property (self_refresh |->
		!dll_en && cke_out == 4'h0)
		else $error("DLL or CKE on in self refresh");
	a_sref_amps: assert property (self_refresh |-> !data_sa_en)
		else $error("data amps on in self refresh");
	a_idle_amps: assert property (!pending && !rd_active |=>
		!data_sa_en)
		else $error("data amps on while idle");
	a_out_amps: assert property (!out_sa_en)
		else $error("output-only amps on");
	a_refresh_up: assert property (refresh_go |->
		cke_out == rank_present)
		else $error("ranks asleep during refresh");
endmodule
bind dcmp_ctrl dcmp_ctrl_monitor i_dcmp_ctrl_monitor (.mclk, .srst,
	.req_valid, .map_valid, .rank_present, .pending, .rd_active,
	.wr_active, .burst_rank, .cke_out, .cs_en, .addr_ctl_oe, .odt_out,
	.own_odt, .dll_en, .data_sa_en, .out_sa_en, .self_refresh, .refresh_go);

// ==== dcmp_dimm_model.sv ====
// Behavioural SO-DIMM pair: link clock, speed codes and refresh timing.
// Assumes mclk at 4 ns; a refresh ends a few cycles after it starts.
module dcmp_dimm_model #(
	parameter logic [2:0] SPD_A = 3'h3, // Slot A speed.
	parameter logic [2:0] SPD_B = 3'h2 // Slot B speed.
) (
	input wire logic mclk, // Clock.
	input wire logic [3:0] ck_en, // Pair enables.
	input wire logic refresh_go, // Refresh.
	output logic link_clk, // Link clock.
	output logic [2:0] spd_freq_a, // Speed A.
	output logic [2:0] spd_freq_b, // Speed B.
	output logic refresh_done // Refresh end.
);
	timeunit 1ns;
	timeprecision 100ps;
	assign spd_freq_a = SPD_A;
	assign spd_freq_b = SPD_B;
	// The clock stops while every pair is gated, as a real slot sees it.
	initial begin
		link_clk = 1'b0;
		#5.3;
		forever begin
			#16;
			link_clk = (ck_en != 4'h0) ? ~link_clk : 1'b0;
		end
	end
	initial begin
		refresh_done = 1'b0;
		forever begin
			@(posedge mclk iff refresh_go !== 1'b1);
			@(posedge mclk iff refresh_go === 1'b1);
			repeat (3) @(posedge mclk);
			#1 refresh_done = 1'b1;
			@(posedge mclk);
			#1 refresh_done = 1'b0;
		end
	end
endmodule

// ==== test_dcmp_ctrl.sv ====
// Self-checking bench for dcmp_ctrl: mapping, termination and power.
// Assumes the SO-DIMM model supplies link clock, speeds and refresh end.
`include "dcmp_consts.svh"
module test_dcmp_ctrl
	import dcmp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, srst, req_valid, req_write, xor_en, pending, rd_active;
	logic wr_active, suspend_req, dpd_en, dpd_mode, refresh_req;
	logic pages_closed, link_clk, refresh_done, map_valid, map_chan;
	logic map_page_8k, precharge_all, refresh_go, addr_ctl_oe, own_odt;
	logic dll_en, data_sa_en, out_sa_en, self_refresh, link_seen;
	logic [`DCMP_ADDR_W-1:0] req_addr, map_addr;
	logic [3:0] req_rank, rank_present, page_8k, burst_rank, ck_en;
	logic [3:0] cke_out, cke_oe, cs_en, odt_out;
	logic [1:0] map_mode, chan_sel_field, receive_enable_timing_dll_en;
	logic [2:0] spd_freq_a, spd_freq_b, mem_freq_sel;
	dcmp_size_t rank_boundary_regs_a, rank_boundary_regs_b;
	int n_errors, n_tests, cyc, seen, i, f;
	dcmp_ctrl i_dcmp_ctrl (.mclk, .srst, .link_clk, .req_valid, .req_write,
		.req_addr, .req_rank, .map_mode, .chan_sel_field, .xor_en,
		.rank_boundary_regs_a, .rank_boundary_regs_b, .rank_present,
		.page_8k, .spd_freq_a, .spd_freq_b, .pending, .rd_active, .wr_active,
		.burst_rank, .suspend_req, .dpd_en, .dpd_mode, .refresh_req,
		.refresh_done, .pages_closed, .map_valid, .map_chan, .map_addr,
		.map_page_8k, .mem_freq_sel, .precharge_all, .refresh_go, .ck_en,
		.cke_out, .cke_oe, .cs_en, .addr_ctl_oe, .odt_out, .own_odt, .dll_en,
		.receive_enable_timing_dll_en, .data_sa_en, .out_sa_en, .self_refresh, .link_seen);
	dcmp_dimm_model i_dcmp_dimm_model (.mclk, .ck_en, .refresh_go,
		.link_clk, .spd_freq_a, .spd_freq_b, .refresh_done);
	task automatic tally_and_finish();
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [35:0] sv, ev);
		n_tests++;
		if (sv !== ev) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, ev, sv);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Requests stay up between calls so back-to-back mapping is exercised.
	task automatic mreq(input logic [32:0] a, input logic ch,
		input logic [32:0] ea, input bit ca);
		req_addr = a;
		req_valid = 1'b1;
		tick(1);
		chk("map_valid", map_valid, 1'b1);
		chk("map_chan", map_chan, ch);
		if (ca)
			chk("map_addr", map_addr, ea);
	endtask
	task automatic do_reset();
		srst = 1'b1;
		tick(12);
		chk("rst cke_out", cke_out, 4'h0);
		chk("rst dll_en", dll_en, 1'b1);
		chk("rst own_odt", own_odt, 1'b0);
		srst = 1'b0;
	endtask
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// Counted on the falling edge so registered outputs have settled.
	always @(negedge mclk) begin
		cyc++;
		if (link_seen === 1'b1)
			seen++;
		if (cyc == 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		{req_valid, req_write, xor_en, rd_active, wr_active} = 5'h00;
		{suspend_req, dpd_en, dpd_mode, refresh_req, pages_closed} = 5'h00;
		{map_mode, chan_sel_field, req_addr, burst_rank} = '0;
		{pending, req_rank, rank_present, page_8k} = 13'h1174;
		rank_boundary_regs_a = 9'h010;
		rank_boundary_regs_b = 9'h020;
		do_reset();
		mreq(33'h0_0fff_ffc0, 1'b0, 33'h0_0fff_ffc0, 1);
		mreq(33'h0_1000_0040, 1'b1, 33'h0_0000_0040, 1);
		map_mode = 2'h2;
		mreq(33'h0_0000_0040, 1'b1, 33'h0, 0);
		mreq(33'h0_0000_0080, 1'b0, 33'h0_0000_0040, 1);
		mreq(33'h0_1fff_ffc0, 1'b1, 33'h0, 0);
		mreq(33'h0_2000_0000, 1'b1, 33'h0_1000_0000, 1);
		xor_en = 1'b1;
		mreq(33'h0_0000_1040, 1'b0, 33'h0, 0);
		xor_en = 1'b0;
		$display("done flex and asym map");
		map_mode = 2'h1;
		rank_boundary_regs_b = 9'h010;
		for (f = 0; f < 4; f++) begin
			chan_sel_field = f[1:0];
			mreq(33'h40 << f, 1'b1, 33'h0, 1);
			mreq(33'hfc0 & ~(33'h40 << f), 1'b0, 33'h7c0, 1);
		end
		req_rank = 4'h4;
		mreq(33'h0, 1'b0, 33'h0, 0);
		chk("page 8k", map_page_8k, 1'b1);
		req_rank = 4'h1;
		mreq(33'h0, 1'b0, 33'h0, 0);
		chk("page 4k", map_page_8k, 1'b0);
		req_valid = 1'b0;
		$display("done full interleave and page");
		tick(3);
		chk("ck_en", ck_en, 4'hf);
		chk("receive_enable_timing", receive_enable_timing_dll_en, 2'h3);
		chk("cke_oe", cke_oe, 4'h7);
		chk("freq", mem_freq_sel, 3'h2);
		rank_present = 4'h3;
		i = seen;
		tick(80);
		chk("ck_en", ck_en, 4'h3);
		chk("receive_enable_timing", receive_enable_timing_dll_en, 2'h1);
		chk("cke_oe", cke_oe, 4'h3);
		chk("freq", mem_freq_sel, 3'h3);
		chk("link_seen", seen - i >= 9 && seen - i <= 11, 1'b1);
		rank_present = 4'h7;
		$display("done slots");
		{wr_active, burst_rank} = 5'h14;
		tick(2);
		chk("odt_out", odt_out, 4'h4);
		chk("own_odt", own_odt, 1'b0);
		burst_rank = 4'h8;
		tick(2);
		chk("odt_out", odt_out, 4'h0);
		{wr_active, rd_active, burst_rank} = 6'h11;
		tick(2);
		chk("odt_out", odt_out, 4'h0);
		chk("own_odt", own_odt, 1'b1);
		chk("data_sa", data_sa_en, 1'b1);
		chk("out_sa", out_sa_en, 1'b0);
		rd_active = 1'b0;
		$display("done termination");
		{dpd_en, dpd_mode, pending} = 3'h6;
		for (i = 0; i < 30 && precharge_all !== 1'b1; i++) tick(1);
		chk("precharge", precharge_all, 1'b1);
		tick(8);
		chk("cke held", cke_out, 4'h7);
		pages_closed = 1'b1;
		for (i = 0; i < 30 && cke_out !== 4'h0; i++) tick(1);
		chk("cke down", cke_out, 4'h0);
		chk("cs_en", cs_en, 4'h0);
		chk("addr_ctl", addr_ctl_oe, 1'b0);
		chk("data_sa", data_sa_en, 1'b0);
		refresh_req = 1'b1;
		for (i = 0; i < 30 && refresh_go !== 1'b1; i++) tick(1);
		refresh_req = 1'b0;
		chk("cke up", cke_out, 4'h7);
		for (i = 0; i < 30 && cke_out !== 4'h0; i++) tick(1);
		chk("cke down", cke_out, 4'h0);
		{dpd_en, pending} = 2'h1;
		do_reset();
		$display("done power-down");
		suspend_req = 1'b1;
		tick(6);
		chk("flush", self_refresh, 1'b0);
		pending = 1'b0;
		for (i = 0; i < 30 && self_refresh !== 1'b1; i++) tick(1);
		chk("sref", self_refresh, 1'b1);
		chk("cke", cke_out, 4'h0);
		chk("dll", dll_en, 1'b0);
		chk("data_sa", data_sa_en, 1'b0);
		chk("cs_en", cs_en, 4'h0);
		suspend_req = 1'b0;
		for (i = 0; i < 30 && dll_en !== 1'b1; i++) tick(1);
		chk("dll back", dll_en, 1'b1);
		$display("done suspend");
		tally_and_finish();
	end
endmodule
